// ==== shared/asr_defines.vh ====
// Timing figures and geometry constants for the asynchronous static memory host
`ifndef ASR_DEFINES_VH
`define ASR_DEFINES_VH

// ------------------------------------------------------------
// Geometry
// ------------------------------------------------------------
`define ASR_ADDR_W          11
`define ASR_DATA_W          8
`define ASR_WORDS           2048

// ------------------------------------------------------------
// Clock
// ------------------------------------------------------------
`define ASR_CLK_PERIOD_PS   8000
`define ASR_SYNC_STAGES     2

// ------------------------------------------------------------
// Pin timings in ns, per speed grade 0 / 1 / 2, except output hold and retention lead, which have one value for all grades
// ------------------------------------------------------------
`define ASR_READ_CYCLE_SPAN_NS_G0         45
`define ASR_READ_CYCLE_SPAN_NS_G1         55
`define ASR_READ_CYCLE_SPAN_NS_G2         70
`define ASR_ADDRESS_ACCESS_DELAY_NS_G0    45
`define ASR_ADDRESS_ACCESS_DELAY_NS_G1    55
`define ASR_ADDRESS_ACCESS_DELAY_NS_G2    70
`define ASR_DRIVE_TO_VALID_DELAY_NS_G0    20
`define ASR_DRIVE_TO_VALID_DELAY_NS_G1    25
`define ASR_DRIVE_TO_VALID_DELAY_NS_G2    50
`define ASR_OUTPUT_HOLD_AFTER_ADDRESS_NS  5
`define ASR_ADDR_VALID_TO_WRITE_END_NS_G0 40
`define ASR_ADDR_VALID_TO_WRITE_END_NS_G1 50
`define ASR_ADDR_VALID_TO_WRITE_END_NS_G2 65
`define ASR_SELECT_TO_WRITE_END_NS_G0     35
`define ASR_SELECT_TO_WRITE_END_NS_G1     40
`define ASR_SELECT_TO_WRITE_END_NS_G2     40
`define ASR_DATA_SETUP_TO_WRITE_END_NS_G0 25
`define ASR_DATA_SETUP_TO_WRITE_END_NS_G1 30
`define ASR_DATA_SETUP_TO_WRITE_END_NS_G2 30
`define ASR_STROBE_TO_FLOAT_DELAY_NS_G0   20
`define ASR_STROBE_TO_FLOAT_DELAY_NS_G1   25
`define ASR_STROBE_TO_FLOAT_DELAY_NS_G2   40
`define ASR_WRITE_RECOVERY_SPAN_NS_G0     0
`define ASR_WRITE_RECOVERY_SPAN_NS_G1     5
`define ASR_WRITE_RECOVERY_SPAN_NS_G2     5
`define ASR_DESELECT_TO_RETENTION_LEAD_NS 0

`endif

// ==== logic/asr_sync.v ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module asr_sync #(
	parameter WIDTH = 8
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] din,
	output wire [WIDTH-1:0] dout
);
	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	// First stage is read only by the second stage
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end
		else
		begin
			meta_q <= din;
			sync_q <= meta_q;
		end
	end

	assign dout = sync_q;
endmodule

// ==== logic/asr_host.v ====
// Host controller that drives a 2K x 8 asynchronous static memory through its pins
// Functional notes
// (R1) Memory holds 2048 words of 8 bits on one shared data bus.
// (R2) Select high puts memory in standby, data floats, other strobes ignored.
// (R3) Memory is fully static; host issues no clock or refresh.
// (R4) Selected with strobe high, memory drives word within access time.
// (R5) Read data valid within drive-to-valid delay after output drive falls.
// (R6) Old read data holds at least 5 ns after an address change.
// (R7) Memory writes only while select and store strobe are both low.
// (R8) Host keeps store strobe high while any address line changes.
// (R9) Host holds address stable for address-valid-to-write-end before write end.
// (R10) Host keeps select low for select-to-write-end before write end.
// (R11) Host places write data for data-setup time before write end.
// (R12) Write ends at the first of select or store strobe going high.
// (R13) Store strobe falling with output drive low floats memory outputs.
// (R14) Select falling with or after strobe keeps memory outputs floating.
// (R15) Host never drives opposing data while memory drives the bus.
// (R16) Early memory drive during a write matches polarity of written word.
// (R17) After a write with output drive low, memory resumes read data.
// (R18) Retention: deselect before entry, wait read cycle span after recovery.
`timescale 1ns/1ps
`include "asr_defines.vh"
module asr_host #(
	parameter GRADE  = 0,
	parameter ADDR_W = `ASR_ADDR_W,
	parameter DATA_W = `ASR_DATA_W
) (
	input  wire              REF_CLK,
	input  wire              RST_N,
	input  wire              REQ,
	input  wire              REQ_WRITE,
	input  wire [ADDR_W-1:0] REQ_ADDR,
	input  wire [DATA_W-1:0] REQ_WDATA,
	output reg               READY,
	output reg               DONE,
	output reg  [DATA_W-1:0] RDATA,
	input  wire              RET_REQ,
	output reg               RET_ACK,
	output reg  [ADDR_W-1:0] MEM_A,
	output reg               MEM_CS_N,
	output reg               MEM_OE_N,
	output reg               MEM_WE_N,
	output reg  [DATA_W-1:0] MEM_DQ_O,
	output reg               MEM_DQ_OE,
	input  wire [DATA_W-1:0] MEM_DQ_I
);
	// ------------------------------------------------------------
	// Timing arithmetic
	// ------------------------------------------------------------
	// Least times round up to whole cycles, never below one
	function [4:0] cyc;
		input integer ns;
		integer t;
		begin
			t = (ns * 1000 + `ASR_CLK_PERIOD_PS - 1) / `ASR_CLK_PERIOD_PS;
			if (t < 1)
				t = 1;
			cyc = t[4:0];
		end
	endfunction

	function integer pick;
		input integer g;
		input integer a;
		input integer b;
		input integer c;
		begin
			pick = (g == 0) ? a : ((g == 1) ? b : c);
		end
	endfunction

	function integer max2;
		input integer a;
		input integer b;
		begin
			max2 = (a > b) ? a : b;
		end
	endfunction

	localparam integer RC_NS  = pick(GRADE, `ASR_READ_CYCLE_SPAN_NS_G0,
		`ASR_READ_CYCLE_SPAN_NS_G1, `ASR_READ_CYCLE_SPAN_NS_G2);
	localparam integer AA_NS  = pick(GRADE, `ASR_ADDRESS_ACCESS_DELAY_NS_G0,
		`ASR_ADDRESS_ACCESS_DELAY_NS_G1, `ASR_ADDRESS_ACCESS_DELAY_NS_G2);
	localparam integer OE_NS  = pick(GRADE, `ASR_DRIVE_TO_VALID_DELAY_NS_G0,
		`ASR_DRIVE_TO_VALID_DELAY_NS_G1, `ASR_DRIVE_TO_VALID_DELAY_NS_G2);
	localparam integer AW_NS  = pick(GRADE, `ASR_ADDR_VALID_TO_WRITE_END_NS_G0,
		`ASR_ADDR_VALID_TO_WRITE_END_NS_G1, `ASR_ADDR_VALID_TO_WRITE_END_NS_G2);
	localparam integer CW_NS  = pick(GRADE, `ASR_SELECT_TO_WRITE_END_NS_G0,
		`ASR_SELECT_TO_WRITE_END_NS_G1, `ASR_SELECT_TO_WRITE_END_NS_G2);
	localparam integer DW_NS  = pick(GRADE, `ASR_DATA_SETUP_TO_WRITE_END_NS_G0,
		`ASR_DATA_SETUP_TO_WRITE_END_NS_G1, `ASR_DATA_SETUP_TO_WRITE_END_NS_G2);
	localparam integer HZ_NS  = pick(GRADE, `ASR_STROBE_TO_FLOAT_DELAY_NS_G0,
		`ASR_STROBE_TO_FLOAT_DELAY_NS_G1, `ASR_STROBE_TO_FLOAT_DELAY_NS_G2);
	localparam integer WR_NS  = pick(GRADE, `ASR_WRITE_RECOVERY_SPAN_NS_G0,
		`ASR_WRITE_RECOVERY_SPAN_NS_G1, `ASR_WRITE_RECOVERY_SPAN_NS_G2);

	// Read waits for both the address path and the drive path, plus synchroniser latency
	localparam [4:0] RD_CNT   = cyc(max2(AA_NS, OE_NS)) + 5'h02;
	// Strobe low long enough to cover address, select and data windows before its rise
	localparam [4:0] WP_CNT   = cyc(max2(max2(AW_NS, CW_NS), DW_NS));
	localparam [4:0] REC_CNT  = cyc(WR_NS);
	localparam [4:0] HZ_CNT   = cyc(HZ_NS);
	localparam [4:0] RC_CNT   = cyc(RC_NS);
	localparam [4:0] CDR_CNT  = cyc(`ASR_DESELECT_TO_RETENTION_LEAD_NS);

	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_RD    = 3'h1;
	localparam [2:0] ST_WSET  = 3'h2;
	localparam [2:0] ST_WPUL  = 3'h3;
	localparam [2:0] ST_WREC  = 3'h4;
	localparam [2:0] ST_TURN  = 3'h5;
	localparam [2:0] ST_RET   = 3'h6;
	localparam [2:0] ST_RREC  = 3'h7;

	reg  [2:0]        state_q;
	reg  [4:0]        cnt_q;
	wire [DATA_W-1:0] dq_sync;

	// Data pins cross into the clock domain before being sampled
	asr_sync #(
		.WIDTH (DATA_W)
	) u_dq_sync (
		.clk   (REF_CLK),
		.rst_n (RST_N),
		.din   (MEM_DQ_I),
		.dout  (dq_sync)
	);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// All pin outputs are flops so no glitch reaches the asynchronous strobes
	always @(posedge REF_CLK)
	begin
		if (!RST_N)
		begin
			state_q   <= ST_IDLE;
			cnt_q     <= 5'h00;
			READY     <= 1'b0;
			DONE      <= 1'b0;
			RDATA     <= {DATA_W{1'b0}};
			RET_ACK   <= 1'b0;
			MEM_A     <= {ADDR_W{1'b0}};
			MEM_CS_N  <= 1'b1;
			MEM_OE_N  <= 1'b1;
			MEM_WE_N  <= 1'b1;
			MEM_DQ_O  <= {DATA_W{1'b0}};
			MEM_DQ_OE <= 1'b0;
		end
		else
		begin
			DONE <= 1'b0;
			case (state_q)
			ST_IDLE:
			begin
				// Standby between accesses; no refresh ever needed
				MEM_CS_N <= 1'b1; // (R2) (R3)
				if (RET_REQ)
				begin
					READY   <= 1'b0;
					cnt_q   <= CDR_CNT;
					state_q <= ST_RET; // (R18)
				end
				else if (REQ && READY)
				begin
					READY <= 1'b0;
					MEM_A <= REQ_ADDR; // (R1) (R8)
					if (REQ_WRITE)
					begin
						MEM_DQ_O  <= REQ_WDATA;
						MEM_DQ_OE <= 1'b1; // (R11)
						MEM_CS_N  <= 1'b0;
						state_q   <= ST_WSET;
					end
					else
					begin
						MEM_CS_N <= 1'b0;
						MEM_OE_N <= 1'b0;
						cnt_q    <= RD_CNT;
						state_q  <= ST_RD; // (R4) (R5)
					end
				end
				else
				begin
					READY <= 1'b1;
				end
			end
			ST_RD:
			begin
				// Address stays put until capture, so the hold window never matters
				if (cnt_q == 5'h01)
				begin
					RDATA    <= dq_sync; // (R4) (R5) (R6)
					DONE     <= 1'b1;
					MEM_CS_N <= 1'b1;
					MEM_OE_N <= 1'b1;
					cnt_q    <= HZ_CNT;
					state_q  <= ST_TURN;
				end
				else
				begin
					cnt_q <= cnt_q - 5'h01;
				end
			end
			ST_WSET:
			begin
				// Address settled a cycle before the strobe falls
				MEM_WE_N <= 1'b0; // (R7) (R8) (R14)
				cnt_q    <= WP_CNT;
				state_q  <= ST_WPUL;
			end
			ST_WPUL:
			begin
				if (cnt_q == 5'h01)
				begin
					// Strobe rises first, so it marks the write end
					MEM_WE_N <= 1'b1; // (R12) (R9) (R10) (R11)
					cnt_q    <= REC_CNT;
					state_q  <= ST_WREC;
				end
				else
				begin
					cnt_q <= cnt_q - 5'h01;
				end
			end
			ST_WREC:
			begin
				// Data and address held through recovery; output drive stays high
				if (cnt_q == 5'h01)
				begin
					MEM_CS_N  <= 1'b1;
					MEM_DQ_OE <= 1'b0; // (R15)
					DONE      <= 1'b1;
					cnt_q     <= 5'h01;
					state_q   <= ST_TURN;
				end
				else
				begin
					cnt_q <= cnt_q - 5'h01;
				end
			end
			ST_TURN:
			begin
				// Bus turnaround: the memory must float before anyone drives again
				if (cnt_q == 5'h01)
				begin
					state_q <= ST_IDLE; // (R15)
				end
				else
				begin
					cnt_q <= cnt_q - 5'h01;
				end
			end
			ST_RET:
			begin
				// Select is already high, so retention may start at once
				if (cnt_q > 5'h01)
				begin
					cnt_q <= cnt_q - 5'h01;
				end
				else
				begin
					RET_ACK <= 1'b1; // (R18)
					if (!RET_REQ)
					begin
						RET_ACK <= 1'b0;
						cnt_q   <= RC_CNT;
						state_q <= ST_RREC;
					end
				end
			end
			ST_RREC:
			begin
				// One full read cycle of recovery before the next access
				if (cnt_q == 5'h01)
				begin
					state_q <= ST_IDLE; // (R18)
				end
				else
				begin
					cnt_q <= cnt_q - 5'h01;
				end
			end
			default:
			begin
				state_q <= ST_IDLE;
			end
			endcase
		end
	end
endmodule

// ==== verif/asr_host_asserts.sv ====
// Pin-sequence checker for the static memory host
`timescale 1ns/1ps
module asr_host_asserts (
	input logic        REF_CLK,
	input logic        RST_N,
	input logic        REQ,
	input logic        REQ_WRITE,
	input logic        RET_REQ,
	input logic        READY,
	input logic        DONE,
	input logic        RET_ACK,
	input logic [10:0] MEM_A,
	input logic        MEM_CS_N,
	input logic        MEM_OE_N,
	input logic        MEM_WE_N,
	input logic [7:0]  MEM_DQ_O,
	input logic        MEM_DQ_OE
);
	// ----------------------------------------
	// Pin rules
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	// Accepted requests and the strobe phase of a write
	sequence s_take_rd; REQ && READY && !RET_REQ && !REQ_WRITE; endsequence
	sequence s_take_wr; REQ && READY && !RET_REQ && REQ_WRITE; endsequence
	sequence s_strobe; (!MEM_WE_N && !MEM_CS_N)[*5] ##1 (MEM_WE_N && !MEM_CS_N); endsequence
	AST_READ_SEQ: assert property (s_take_rd |=> (!MEM_CS_N && !MEM_OE_N && MEM_WE_N)[*8] ##1 (DONE && MEM_CS_N))
		else $error("read strobe sequence wrong");
	AST_WRITE_SEQ: assert property (s_take_wr |=> (!MEM_CS_N && MEM_WE_N && MEM_DQ_OE) ##1 s_strobe ##1 MEM_CS_N)
		else $error("write strobe sequence wrong");
	AST_NO_WE_OE: assert property (!(!MEM_OE_N && !MEM_WE_N))
		else $error("output drive low during a store");
	AST_ADDR_HOLD: assert property ((!MEM_WE_N || $rose(MEM_WE_N)) |-> $stable(MEM_A))
		else $error("address moved around a store");
	AST_DATA_HOLD: assert property (!MEM_WE_N |-> MEM_DQ_OE && $stable(MEM_DQ_O))
		else $error("write data not held");
	AST_WE_AFTER_CS: assert property ($fell(MEM_WE_N) |-> $past(MEM_CS_N) == 1'b0)
		else $error("strobe fell before select");
	AST_OE_BUS: assert property (!MEM_OE_N |-> !MEM_CS_N && !MEM_DQ_OE)
		else $error("bus fight on read");
	AST_RET_DESEL: assert property (RET_ACK |-> MEM_CS_N && MEM_WE_N)
		else $error("selected during retention");
endmodule
bind asr_host asr_host_asserts u_asr_host_asserts (.REF_CLK(REF_CLK), .RST_N(RST_N), .REQ(REQ),
	.REQ_WRITE(REQ_WRITE), .RET_REQ(RET_REQ), .READY(READY), .DONE(DONE), .RET_ACK(RET_ACK),
	.MEM_A(MEM_A), .MEM_CS_N(MEM_CS_N), .MEM_OE_N(MEM_OE_N), .MEM_WE_N(MEM_WE_N),
	.MEM_DQ_O(MEM_DQ_O), .MEM_DQ_OE(MEM_DQ_OE));

// ==== verif/asr_mem_model.sv ====
// Behavioural 2K x 8 static memory seen from its pins
`timescale 1ns/1ps
module asr_mem_model #(
	parameter ACC_NS = 45
) (
	input  wire [10:0] a,
	input  wire        cs_n,
	input  wire        oe_n,
	input  wire        we_n,
	input  wire [7:0]  dq_in,
	output wire [7:0]  dq_out
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// Plain array: contents stay with no clock or refresh
	reg  [7:0] mem_q [0:2047];
	wire [7:0] rd_w;
	wire       drv_w;
	// Stores only in the select and strobe overlap, so the first rise ends it
	always @*
		if (!cs_n && !we_n)
			mem_q[a] = dq_in;
	// Drives only when selected with strobe high; a store floats the bus
	assign drv_w = !cs_n && !oe_n && we_n;
	// Inertial delay: a slow grade is just a larger ACC_NS
	assign #(ACC_NS) rd_w = mem_q[a];
	// Released bus shows the inverse, so stale data never passes
	assign dq_out = drv_w ? rd_w : ~rd_w;
endmodule

// ==== verif/asr_host_tb.sv ====
// Self-checking testbench for the static memory host
`timescale 1ns/1ps
module asr_host_tb;
	logic        ref_clk = 0;
	logic        rst_n = 0;
	logic        req = 0;
	logic        req_write = 0;
	logic [10:0] req_addr = 0;
	logic [7:0]  req_wdata = 0;
	logic        ret_req = 0;
	wire         ready, done, ret_ack, cs_n, oe_n, we_n, dq_oe;
	wire [7:0]   rdata, dq_o, dq_m, dq_w;
	wire [10:0]  mem_a;
	int          fails = 0;
	int          num_checks = 0;
	logic [10:0] addr_t [4] = '{11'h000, 11'h7FF, 11'h155, 11'h2AA};
	logic [7:0]  data_t [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
	// ----------------------------------------
	// Clock, design, memory
	// ----------------------------------------
	always #4 ref_clk = ~ref_clk;
	// Wire level: host wins when it drives, else the memory side
	assign dq_w = dq_oe ? dq_o : dq_m;
	asr_host u_asr_host (.REF_CLK(ref_clk), .RST_N(rst_n), .REQ(req), .REQ_WRITE(req_write),
		.REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .READY(ready), .DONE(done), .RDATA(rdata),
		.RET_REQ(ret_req), .RET_ACK(ret_ack), .MEM_A(mem_a), .MEM_CS_N(cs_n), .MEM_OE_N(oe_n),
		.MEM_WE_N(we_n), .MEM_DQ_O(dq_o), .MEM_DQ_OE(dq_oe), .MEM_DQ_I(dq_w));
	asr_mem_model u_asr_mem_model (.a(mem_a), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .dq_in(dq_w),
		.dq_out(dq_m));
	// ----------------------------------------
	// Compare, finish, access
	// ----------------------------------------
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("FAIL %0t %s", $time, what);
		end
	endtask
	task summarize;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// One access; lat counts edges from take until DONE is seen
	task automatic op(input logic wr, input logic [10:0] ad, input logic [7:0] wd, output int lat);
		int n;
		@(posedge ref_clk);
		req <= 1'b1;
		req_write <= wr;
		req_addr <= ad;
		req_wdata <= wd;
		n = 0;
		do @(posedge ref_clk); while (ready !== 1'b1 && ++n < 50);
		req <= 1'b0;
		lat = 0;
		do @(posedge ref_clk); while (done !== 1'b1 && ++lat < 50);
		// A request never taken or never answered is a mismatch, not a silent pass
		chk_byte(8'(n < 50 && lat < 50), 8'h01, "access timed out");
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Pins idle and deselected while reset is held
	task t_reset;
		repeat (8) @(posedge ref_clk);
		chk_byte({4'h0, cs_n, oe_n, we_n, dq_oe}, 8'h0E, "pins not idle in reset");
		chk_byte({7'h00, ready}, 8'h00, "ready in reset");
		rst_n <= 1'b1;
	endtask
	// Boundary addresses and patterns written, then read back at full latency
	task automatic t_rw;
		int lat;
		for (int i = 0; i < 4; i++)
			op(1'b1, addr_t[i], data_t[i], lat);
		for (int i = 0; i < 4; i++)
		begin
			op(1'b0, addr_t[i], 8'h00, lat);
			chk_byte(rdata, data_t[i], "read back");
			chk_byte(8'(lat), 8'h08, "read latency");
		end
	endtask
	// Overwrite straight after a read of the same word
	task automatic t_b2b;
		int lat;
		op(1'b1, 11'h123, 8'h3C, lat);
		op(1'b0, 11'h123, 8'h00, lat);
		chk_byte(rdata, 8'h3C, "first value");
		op(1'b1, 11'h123, 8'hC3, lat);
		op(1'b0, 11'h123, 8'h00, lat);
		chk_byte(rdata, 8'hC3, "overwrite");
	endtask
	// Retention entry deselects; recovery waits a read cycle; data kept
	task automatic t_ret;
		int n;
		int lat;
		@(posedge ref_clk);
		ret_req <= 1'b1;
		n = 0;
		do @(posedge ref_clk); while (ret_ack !== 1'b1 && ++n < 20);
		chk_byte({6'h00, ret_ack, cs_n}, 8'h03, "retention not deselected");
		repeat (20) @(posedge ref_clk);
		ret_req <= 1'b0;
		n = 0;
		do @(posedge ref_clk); while (ready !== 1'b1 && ++n < 50);
		chk_byte(8'(n >= 7 && n < 50), 8'h01, "recovery span");
		op(1'b0, addr_t[0], 8'h00, lat);
		chk_byte(rdata, data_t[0], "data lost");
	endtask
	// Reset again mid-run: pins return to idle, stored words survive, reads restart cleanly
	task automatic t_midrst;
		int lat;
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk_byte({3'h0, ready, cs_n, oe_n, we_n, dq_oe}, 8'h0E, "pins not idle in second reset");
		rst_n <= 1'b1;
		op(1'b0, addr_t[1], 8'h00, lat);
		chk_byte(rdata, data_t[1], "data lost over reset");
		chk_byte(8'(lat), 8'h08, "read latency after reset");
	endtask
	// Watchdog: whole run is a few hundred cycles
	initial
	begin
		#100000;
		fails++;
		summarize();
	end
	initial
	begin
		t_reset();
		t_rw();
		t_b2b();
		t_ret();
		t_midrst();
		summarize();
	end
endmodule
